// ---- verilog/byte_op_instruction_decoder.v ----
// Instruction decode and execute core for 14-bit words of the 8-bit controller.
// Assumes a program memory giving the word at prog_addr combinationally, and a
// register file whose read data stands while its one-clock read strobe is high.
//
// Notes on behaviour
// (RULE1) Each instruction is one 14-bit word
// (RULE2) Three groups: byte, bit, literal/control
// (RULE3) Byte ops: 00, opcode, destination, address
// (RULE4) Register address spans 0x00 to 0x7F
// (RULE5) Destination 0 accumulator, 1 register
// (RULE6) Three bits pick bit of register
// (RULE7) Literal 8 bits, branch target 11 bits
// (RULE8) Instruction cycle is four clocks
// (RULE9) Skip or jump adds one NOP cycle
// (RULE10) Register operand always read before write
// (RULE11) Port clear still reads the port
// (RULE12) Rotates go through carry, carry only
// (RULE13) Count-and-skip skips on zero, no flags
// (RULE14) AND, OR, XOR update zero only
// (RULE15) Carry, half carry, zero, timeout, sleep flags
// (RULE16) Port self-modify reads pin levels
// (RULE17) Timer zero write clears assigned prescaler
// (RULE18) Don't-care encoding bits are ignored
// (RULE19) Add and subtract update carry, half carry, zero
`timescale 1ns/1ps
`include "byte_op_defs.vh"

module byte_op_instruction_decoder (
	// Clock and reset
	input  wire        clk,
	input  wire        srst,
	// Program memory
	output reg  [10:0] prog_addr,
	input  wire [13:0] instr_word,
	// Register file
	output reg  [6:0]  rf_addr,
	output reg         rf_rd_en,
	input  wire [7:0]  rf_rd_data,
	output reg         rf_wr_en,
	output reg  [7:0]  rf_wr_data,
	// Port and timer side effects
	input  wire [7:0]  port_pins,
	output reg         port_read,
	output reg         prescaler_clear,
	input  wire        wdog_expired,
	// Software register port
	input  wire [3:0]  sw_addr,
	input  wire [7:0]  sw_wdata,
	input  wire        sw_we,
	input  wire        sw_re,
	output reg  [7:0]  sw_rdata
);

////////////////////////////////////////////////////////////////////////////////
// Arithmetic helpers

// Add with carry in, carry out in the top bit
function [8:0] add9;
	input [7:0] a;
	input [7:0] b;
	input       cin;
	begin
		add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	end
endfunction

// Nibble add, carry out gives the half carry
function [4:0] add5;
	input [3:0] a;
	input [3:0] b;
	input       cin;
	begin
		add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

localparam PH_FETCH = 2'd0;
localparam PH_READ  = 2'd1;
localparam PH_LATCH = 2'd2;
localparam PH_EXEC  = 2'd3;

reg  [1:0]  phase;
reg  [13:0] ir;
reg  [7:0]  acc;
reg  [7:0]  operand;
reg         flag_c;
reg         flag_dc;
reg         flag_z;
reg         watchdog_timeout_flag;
reg         sleep_entry_flag;
reg         skip_pending;
reg         nop_cycle;
reg         jump_hold;
reg  [7:0]  ctrl;

wire        run      = ctrl[`CTRL_RUN];
wire [1:0]  grp      = ir[`GRP_HI:`GRP_LO];
wire [3:0]  op       = ir[`OP_HI:`OP_LO];
wire        dest     = ir[`DEST_BIT];
wire [6:0]  faddr    = ir[`FADDR_HI:0];
wire [2:0]  bsel     = ir[`BIT_HI:`BIT_LO];
wire [1:0]  bop      = ir[`BOP_HI:`BOP_LO];
wire [7:0]  k8       = ir[`K8_HI:0];
wire [10:0] k11      = ir[`K11_HI:0];
wire        uses_reg = (grp == `GRP_BYTE) || (grp == `GRP_BIT);

////////////////////////////////////////////////////////////////////////////////
// Execute stage, combinational

reg  [7:0] next_res;
reg        next_c;
reg        next_dc;
reg        next_z;
reg        next_to;
reg        next_sleep;
reg        wr_reg;
reg        wr_acc;
reg        skip;
reg        jump;
reg  [8:0] sum;
reg  [4:0] half;
reg  [7:0] bmask;

// Result, destination and flags for the word held in ir
always @* begin
	next_res = 8'h00;
	next_c   = flag_c;
	next_dc  = flag_dc;
	next_z   = flag_z;
	next_to  = watchdog_timeout_flag;
	next_sleep = sleep_entry_flag;
	wr_reg   = 1'b0;
	wr_acc   = 1'b0;
	skip     = 1'b0;
	jump     = 1'b0;
	sum      = 9'h000;
	half     = 5'h00;
	bmask    = 8'h01 << bsel; // RULE6
	case (grp) // RULE2
	`GRP_BYTE: begin // RULE3
		wr_reg = dest; // RULE5
		wr_acc = ~dest; // RULE5
		case (op)
		`OP_MOVE_OR_CTL: begin
			next_res = acc;
			wr_acc   = 1'b0;
			if (!dest && faddr == `CTL_CLR_WDOG) begin
				next_to    = 1'b1; // RULE15
				next_sleep = 1'b1;
			end else if (!dest && faddr == `CTL_SLEEP) begin
				next_to    = 1'b1; // RULE15
				next_sleep = 1'b0;
			end
		end
		`OP_CLEAR: begin
			// Address bits are ignored when clearing the accumulator
			next_res = 8'h00; // RULE18
			next_z   = 1'b1;
		end
		`OP_SUB: begin
			sum      = add9(operand, ~acc, 1'b1);
			half     = add5(operand[3:0], ~acc[3:0], 1'b1);
			next_res = sum[7:0];
			next_c   = sum[8]; // RULE19
			next_dc  = half[4]; // RULE19
			next_z   = (sum[7:0] == 8'h00); // RULE19
		end
		`OP_ADD: begin
			sum      = add9(operand, acc, 1'b0);
			half     = add5(operand[3:0], acc[3:0], 1'b0);
			next_res = sum[7:0];
			next_c   = sum[8]; // RULE19
			next_dc  = half[4]; // RULE19
			next_z   = (sum[7:0] == 8'h00); // RULE19
		end
		`OP_DEC: begin
			next_res = operand - 8'h01;
			next_z   = (next_res == 8'h00);
		end
		`OP_INC: begin
			next_res = operand + 8'h01;
			next_z   = (next_res == 8'h00);
		end
		`OP_IOR: begin
			next_res = operand | acc;
			next_z   = (next_res == 8'h00); // RULE14
		end
		`OP_AND: begin
			next_res = operand & acc;
			next_z   = (next_res == 8'h00); // RULE14
		end
		`OP_XOR: begin
			next_res = operand ^ acc;
			next_z   = (next_res == 8'h00); // RULE14
		end
		`OP_MOVE_REG: begin
			next_res = operand;
			next_z   = (operand == 8'h00);
		end
		`OP_COMPLEMENT: begin
			next_res = ~operand;
			next_z   = (operand == 8'hff);
		end
		`OP_DEC_SKIP: begin
			// Flags untouched, only the skip decision
			next_res = operand - 8'h01; // RULE13
			skip     = (next_res == 8'h00); // RULE13
		end
		`OP_INC_SKIP: begin
			next_res = operand + 8'h01; // RULE13
			skip     = (next_res == 8'h00); // RULE13
		end
		`OP_ROT_RIGHT: begin
			next_res = {flag_c, operand[7:1]}; // RULE12
			next_c   = operand[0]; // RULE12
		end
		`OP_ROT_LEFT: begin
			next_res = {operand[6:0], flag_c}; // RULE12
			next_c   = operand[7]; // RULE12
		end
		`OP_SWAP: begin
			next_res = {operand[3:0], operand[7:4]};
		end
		default: begin
			next_res = operand;
		end
		endcase
	end
	`GRP_BIT: begin
		case (bop)
		`BOP_CLEAR: begin
			next_res = operand & ~bmask; // RULE6
			wr_reg   = 1'b1;
		end
		`BOP_SET: begin
			next_res = operand | bmask; // RULE6
			wr_reg   = 1'b1;
		end
		`BOP_SKIP_CLR: begin
			skip = ((operand & bmask) == 8'h00); // RULE6
		end
		default: begin
			skip = ((operand & bmask) != 8'h00); // RULE6
		end
		endcase
	end
	`GRP_BRANCH: begin
		jump = 1'b1; // RULE7
	end
	default: begin
		// Only move and OR literal are decoded; the rest act as no-ops
		if (ir[`OP_HI:`BOP_LO] == `LIT_MOVE) begin
			next_res = k8; // RULE7
			wr_acc   = 1'b1;
		end else if (op == `LIT_IOR) begin
			next_res = acc | k8; // RULE7
			next_z   = ((acc | k8) == 8'h00);
			wr_acc   = 1'b1;
		end
	end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Four phase sequencer and core registers

wire       exec_now = run && (phase == PH_EXEC) && !nop_cycle;
wire [7:0] port_sel = (faddr == `ADDR_PORT_A) ? port_pins : rf_rd_data; // RULE16

// One instruction cycle is four clocks; a stopped core holds at its current phase
always @(posedge clk) begin
	if (srst) begin
		phase           <= PH_FETCH;
		ir              <= 14'h0000;
		operand         <= 8'h00;
		prog_addr       <= `PROG_RESET;
		skip_pending    <= 1'b0;
		nop_cycle       <= 1'b0;
		jump_hold       <= 1'b0;
		rf_addr         <= 7'h00;
		rf_rd_en        <= 1'b0;
		rf_wr_en        <= 1'b0;
		rf_wr_data      <= 8'h00;
		port_read       <= 1'b0;
		prescaler_clear <= 1'b0;
	end else begin
		rf_rd_en        <= 1'b0;
		rf_wr_en        <= 1'b0;
		port_read       <= 1'b0;
		prescaler_clear <= 1'b0;
		if (run) begin
			phase <= phase + 2'd1; // RULE8
			case (phase)
			PH_FETCH: begin
				ir           <= instr_word; // RULE1
				nop_cycle    <= skip_pending; // RULE9
				skip_pending <= 1'b0;
			end
			PH_READ: begin
				// Reads happen even for pure writes such as clear
				if (uses_reg && !nop_cycle) begin
					rf_addr   <= faddr; // RULE4
					rf_rd_en  <= 1'b1; // RULE10
					port_read <= (faddr == `ADDR_PORT_A); // RULE11
				end
			end
			PH_LATCH: begin
				operand <= port_sel; // RULE16
			end
			PH_EXEC: begin
				if (!nop_cycle && jump) begin
					prog_addr    <= k11; // RULE9
					skip_pending <= 1'b1; // RULE9
					jump_hold    <= 1'b1;
				end else begin
					// The filler cycle after a branch must not step past the target
					if (!jump_hold)
						prog_addr <= prog_addr + 11'd1;
					jump_hold    <= 1'b0;
					skip_pending <= !nop_cycle && skip; // RULE9
				end
				if (!nop_cycle && wr_reg) begin
					rf_wr_en   <= 1'b1; // RULE5
					rf_wr_data <= next_res;
					prescaler_clear <= (faddr == `ADDR_TIMER0) &&
						ctrl[`CTRL_PRESC_T0]; // RULE17
				end
			end
			default: begin
				phase <= PH_FETCH;
			end
			endcase
		end
	end
end

// Accumulator and status flags
always @(posedge clk) begin
	if (srst) begin
		acc                   <= `ACC_RESET;
		flag_c                <= 1'b0;
		flag_dc               <= 1'b0;
		flag_z                <= 1'b0;
		watchdog_timeout_flag <= 1'b1;
		sleep_entry_flag      <= 1'b1;
	end else begin
		if (exec_now) begin
			flag_c           <= next_c; // RULE15
			flag_dc          <= next_dc;
			flag_z           <= next_z;
			sleep_entry_flag <= next_sleep;
		end
		// A time-out in the same clock as a watchdog clear wins
		if (wdog_expired)
			watchdog_timeout_flag <= 1'b0; // RULE15
		else if (exec_now)
			watchdog_timeout_flag <= next_to;
		// Core write has priority over a software write
		if (exec_now && wr_acc)
			acc <= next_res; // RULE5
		else if (sw_we && sw_addr == `SW_ACC)
			acc <= sw_wdata;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Software register port

// Control register write
always @(posedge clk) begin
	if (srst)
		ctrl <= `CTRL_RESET;
	else if (sw_we && sw_addr == `SW_CTRL)
		ctrl <= {6'h00, sw_wdata[1:0]};
end

// Read data stands one clock after the strobe, zero when idle or unmapped
always @(posedge clk) begin
	if (srst) begin
		sw_rdata <= 8'h00;
	end else if (sw_re) begin
		case (sw_addr)
		`SW_CTRL:   sw_rdata <= ctrl;
		`SW_STATUS: sw_rdata <= {3'b000, watchdog_timeout_flag, sleep_entry_flag,
			flag_z, flag_dc, flag_c};
		`SW_ACC:    sw_rdata <= acc;
		`SW_PROG_LO: sw_rdata <= prog_addr[7:0];
		`SW_PROG_HI: sw_rdata <= {5'h00, prog_addr[10:8]};
		`SW_IR_LO:  sw_rdata <= ir[7:0];
		`SW_IR_HI:  sw_rdata <= {2'b00, ir[13:8]};
		default:    sw_rdata <= 8'h00;
		endcase
	end else begin
		sw_rdata <= 8'h00;
	end
end

endmodule // byte_op_instruction_decoder

// ---- verilog/byte_op_defs.vh ----
// Constants for the byte operation instruction decoder.
// Assumes inclusion by the core file only; definitions, no logic.
`ifndef BYTE_OP_DEFS_VH
`define BYTE_OP_DEFS_VH

// Instruction word and field layout
`define IW_WIDTH        14
`define GRP_HI          13
`define GRP_LO          12
`define OP_HI           11
`define OP_LO           8
`define DEST_BIT        7
`define FADDR_HI        6
`define BIT_HI          9
`define BIT_LO          7
`define BOP_HI          11
`define BOP_LO          10
`define K8_HI           7
`define K11_HI          10

// Instruction groups
`define GRP_BYTE        2'b00
`define GRP_BIT         2'b01
`define GRP_BRANCH      2'b10
`define GRP_LITERAL     2'b11

// Whole byte operation codes
`define OP_MOVE_OR_CTL  4'b0000
`define OP_CLEAR        4'b0001
`define OP_SUB          4'b0010
`define OP_DEC          4'b0011
`define OP_IOR          4'b0100
`define OP_AND          4'b0101
`define OP_XOR          4'b0110
`define OP_ADD          4'b0111
`define OP_MOVE_REG     4'b1000
`define OP_COMPLEMENT   4'b1001
`define OP_INC          4'b1010
`define OP_DEC_SKIP     4'b1011
`define OP_ROT_RIGHT    4'b1100
`define OP_ROT_LEFT     4'b1101
`define OP_SWAP         4'b1110
`define OP_INC_SKIP     4'b1111

// Bit operation codes
`define BOP_CLEAR       2'b00
`define BOP_SET         2'b01
`define BOP_SKIP_CLR    2'b10
`define BOP_SKIP_SET    2'b11

// Control words in the 0000 space and literal codes
`define CTL_CLR_WDOG    7'h64
`define CTL_SLEEP       7'h63
`define LIT_MOVE        2'b00
`define LIT_IOR         4'b1000

// Special register file addresses
`define ADDR_PORT_A     7'h05
`define ADDR_TIMER0     7'h01

// Timing: oscillator periods per instruction cycle
`define PERIODS_PER_CYC 3'd4

// Software register offsets
`define SW_CTRL         4'h0
`define SW_STATUS       4'h1
`define SW_ACC          4'h2
`define SW_PROG_LO      4'h3
`define SW_PROG_HI      4'h4
`define SW_IR_LO        4'h5
`define SW_IR_HI        4'h6

// Control bit positions and reset values
`define CTRL_RUN        0
`define CTRL_PRESC_T0   1
`define CTRL_RESET      8'h00
`define ACC_RESET       8'h00
`define PROG_RESET      11'h000

`endif

// ---- testbench/decoder_properties.sv ----
// Port timing properties of the decoder core.
// Assumes it is bound into byte_op_instruction_decoder.
`timescale 1ns/1ps
module decoder_props (
	// Clock and reset
	input wire        clk,
	input wire        srst,
	// Core side
	input wire [10:0] prog_addr,
	input wire [6:0]  rf_addr,
	input wire        rf_rd_en,
	input wire        rf_wr_en,
	input wire        port_read,
	input wire        prescaler_clear
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	////////////////////////////////
	// Write only after a read, two or three clocks before
	property p_read_first; rf_wr_en |-> $past(rf_rd_en, 2) || $past(rf_rd_en, 3); endproperty
	a_read_first: assert property (p_read_first) else $error("write without read");
	// Write lands on the address that was read
	property p_same; rf_wr_en |-> rf_addr == $past(rf_addr, 2); endproperty
	a_same: assert property (p_same) else $error("write address moved");
	// Port read pulse goes with a read of the port only
	property p_prd; rf_rd_en |-> port_read == (rf_addr == 7'h05); endproperty
	a_prd: assert property (p_prd) else $error("port read wrong");
	property p_prd_only; port_read |-> rf_rd_en; endproperty
	a_prd_only: assert property (p_prd_only) else $error("stray port read");
	// Prescaler clear only on a write of the timer count
	property p_pcl; prescaler_clear |-> rf_wr_en && rf_addr == 7'h01; endproperty
	a_pcl: assert property (p_pcl) else $error("stray prescaler clear");
	// At most one read, one write and one fetch step per four clocks
	property p_rd_gap; rf_rd_en |=> !rf_rd_en [*3]; endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("reads too close");
	property p_wr_gap; rf_wr_en |=> !rf_wr_en [*3]; endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("writes too close");
	property p_pc_gap; $changed(prog_addr) |=> $stable(prog_addr) [*3]; endproperty
	a_pc_gap: assert property (p_pc_gap) else $error("fetch too soon");
	c_wr: cover property (rf_wr_en);
	c_prd: cover property (port_read);
	c_pcl: cover property (prescaler_clear);
endmodule // decoder_props

bind byte_op_instruction_decoder decoder_props u_props (
	.clk(clk), .srst(srst), .prog_addr(prog_addr), .rf_addr(rf_addr),
	.rf_rd_en(rf_rd_en), .rf_wr_en(rf_wr_en), .port_read(port_read),
	.prescaler_clear(prescaler_clear)
);

// ---- testbench/core_mem_model.sv ----
// Program memory and register file facing the decoder core.
// Assumes the bench preloads prog and regs by hierarchical name.
`timescale 1ns/1ps
module core_mem_model (
	// Clock
	input  wire        clk,
	// Program memory
	input  wire [10:0] prog_addr,
	output wire [13:0] instr_word,
	// Register file
	input  wire [6:0]  rf_addr,
	input  wire        rf_rd_en,
	output wire [7:0]  rf_rd_data,
	input  wire        rf_wr_en,
	input  wire [7:0]  rf_wr_data
);
	reg [13:0] prog [0:2047];
	reg [7:0]  regs [0:127];
	////////////////////////////////
	// Fetch is combinational on the program counter
	assign instr_word = prog[prog_addr];
	// Data stands only under the strobe; the inverse otherwise, so early or late never matches
	assign rf_rd_data = rf_rd_en ? regs[rf_addr] : ~regs[rf_addr];
	// Writes land at the edge that samples the strobe
	always @(posedge clk) begin
		if (rf_wr_en)
			regs[rf_addr] <= rf_wr_data;
	end
endmodule // core_mem_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the byte operation decoder core.
// Assumes the memory model and the property checker compile first.
`timescale 1ns/1ps
module testbench;
	reg         clk, srst, sw_we, sw_re, wdog;
	reg  [3:0]  sw_addr;
	reg  [7:0]  sw_wdata, pins, q;
	reg  [31:0] r;
	wire [10:0] pa;
	wire [13:0] iw;
	wire [6:0]  ra;
	wire [7:0]  rd, wd, sw_rdata;
	wire        re, we, prd, pcl;
	integer     errors, comparisons, nrd, nprd, npcl, i;

	byte_op_instruction_decoder DUT (.clk(clk), .srst(srst), .prog_addr(pa),
		.instr_word(iw), .rf_addr(ra), .rf_rd_en(re), .rf_rd_data(rd),
		.rf_wr_en(we), .rf_wr_data(wd), .port_pins(pins), .port_read(prd),
		.prescaler_clear(pcl), .wdog_expired(wdog), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata));
	core_mem_model mem (.clk(clk), .prog_addr(pa), .instr_word(iw), .rf_addr(ra),
		.rf_rd_en(re), .rf_rd_data(rd), .rf_wr_en(we), .rf_wr_data(wd));

	////////////////////////////////
	// Clock and pulse counters
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		nrd = nrd + re;
		nprd = nprd + prd;
		npcl = npcl + pcl;
	end

	task check(input [7:0] seen, input [7:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task sw_wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge clk);
			sw_we <= 1'b1;
			sw_addr <= a;
			sw_wdata <= d;
			@(posedge clk);
			sw_we <= 1'b0;
		end
	endtask

	// Data is taken mid-cycle after the strobe, where it stands alone
	task sw_rd(input [3:0] a, output [7:0] d);
		begin
			@(posedge clk);
			sw_re <= 1'b1;
			sw_addr <= a;
			@(posedge clk);
			sw_re <= 1'b0;
			@(negedge clk);
			d = sw_rdata;
		end
	endtask

	// Result in the low byte, status after reset in the high byte
	function [15:0] expect_op(input [3:0] op, input [7:0] a, input [7:0] v);
		reg [8:0] s;
		reg [4:0] h;
		reg [7:0] st;
		begin
			st = 8'h18;
			case (op)
			4'b0111: s = {1'b0, v} + a;
			4'b0010: s = {1'b0, v} - a;
			4'b0101: s = {1'b0, v & a};
			4'b0100: s = {1'b0, v | a};
			4'b0110: s = {1'b0, v ^ a};
			4'b1101: s = {v, 1'b0};
			4'b1100: s = {v[0], 1'b0, v[7:1]};
			4'b1011: s = {1'b0, v} - 9'h001;
			4'b1111: s = {1'b0, v} + 9'h001;
			4'b0011: s = {1'b0, v} - 9'h001;
			4'b1010: s = {1'b0, v} + 9'h001;
			4'b1000: s = {1'b0, v};
			4'b1001: s = {1'b0, ~v};
			4'b1110: s = {1'b0, v[3:0], v[7:4]};
			4'b0000: s = {1'b0, a};
			default: s = 9'h000;
			endcase
			h = (op == 4'b0010) ? {1'b0, v[3:0]} - a[3:0] : {1'b0, v[3:0]} + a[3:0];
			if (op == 4'b0111 || op == 4'b0010)
				st[1:0] = {h[4], s[8]} ^ {2{op == 4'b0010}};
			if (op[3:1] == 3'b110)
				st[0] = s[8];
			if (op != 4'b0000 && op <= 4'b1010)
				st[2] = (s[7:0] == 8'h00);
			expect_op = {st, s[7:0]};
		end
	endfunction

	// One instruction from reset, then a branch loop at the next address
	// Group g: 00 byte, 01 bit (select {op[1:0], d}), 11 literal ({d, f})
	task run(input [3:0] op, input d, input [6:0] f, input [7:0] a, input [7:0] v,
		input ps, input [1:0] g);
		reg [15:0] e;
		reg [7:0]  m, x;
		integer    n0, n1, n2;
		reg        skip, wr, wa;
		begin
			@(posedge clk);
			pins <= v ^ 8'h5a;
			srst <= 1'b1;
			repeat (2) @(posedge clk);
			srst <= 1'b0;
			x = (f == 7'h05) ? pins : v;
			e = expect_op(op, a, x);
			skip = (op == 4'b1011 || op == 4'b1111) && e[7:0] == 8'h00;
			wr = d;
			wa = !d && op != 4'b0000;
			if (op == 4'b0000 && !d && f == 7'h63)
				e[11] = 1'b0;
			m = 8'h01 << {op[1:0], d};
			if (g == 2'b01) begin
				e = {8'h18, op[2] ? (x | m) : (x & ~m)};
				skip = op[3] && (((x & m) != 8'h00) == op[2]);
				wr = !op[3];
				wa = 1'b0;
			end else if (g == 2'b11) begin
				wr = 1'b0;
				wa = (op[3:2] == 2'b00) || (op == 4'b1000);
				e[7:0] = (op == 4'b1000) ? (a | {d, f}) : {d, f};
				e[15:8] = {5'h03, (op == 4'b1000) && e[7:0] == 8'h00, 2'b00};
				skip = 1'b0;
			end
			mem.prog[0] = {g, op, d, f};
			mem.regs[f] = v;
			n0 = nrd;
			n1 = nprd;
			n2 = npcl;
			sw_wr(4'h2, a);
			sw_wr(4'h0, {6'h00, ps, 1'b1});
			repeat (16) @(posedge clk);
			sw_wr(4'h0, 8'h00);
			sw_rd(4'h2, q);
			check(q, wa ? e[7:0] : a);
			sw_rd(4'h1, q);
			check(q, e[15:8]);
			sw_rd(4'h3, q);
			check(q, {7'h00, skip} + 8'h01);
			check(mem.regs[f], wr ? e[7:0] : v);
			check(8'(nrd - n0), {7'h00, !g[1]});
			check(8'(nprd - n1), {7'h00, !g[1] && f == 7'h05});
			check(8'(npcl - n2), {7'h00, ps && wr && f == 7'h01});
			$display("test group %b op %b f %h done", g, op, f);
		end
	endtask

	task test_done;
		begin
			$display("comparisons %0d errors %0d", comparisons, errors);
			if (errors == 0 && comparisons > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	////////////////////////////////
	// Corner cases first, then every byte, bit and literal code with random operands
	initial begin
		{srst, sw_we, sw_re, wdog, sw_addr, sw_wdata, pins} = {4'b1000, 20'h0_0000};
		{errors, comparisons, nrd, nprd, npcl} = 0;
		mem.prog[1] = 14'h2001;
		mem.prog[2] = 14'h2002;
		r = $urandom(3);
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		sw_rd(4'h1, q);
		check(q, 8'h18);
		sw_rd(4'h7, q);
		check(q, 8'h00);
		// A watchdog expiry pulse drops the time-out flag
		@(posedge clk);
		wdog <= 1'b1;
		@(posedge clk);
		wdog <= 1'b0;
		sw_rd(4'h1, q);
		check(q, 8'h08);
		run(4'b1111, 1'b1, 7'h20, 8'h00, 8'hff, 1'b0, 2'b00);
		run(4'b1011, 1'b0, 7'h7f, 8'h00, 8'h01, 1'b0, 2'b00);
		run(4'b0001, 1'b1, 7'h05, 8'h33, 8'h5a, 1'b0, 2'b00);
		run(4'b1101, 1'b1, 7'h05, 8'h00, 8'h81, 1'b0, 2'b00);
		run(4'b0111, 1'b1, 7'h01, 8'h01, 8'hff, 1'b1, 2'b00);
		run(4'b0010, 1'b0, 7'h00, 8'h4c, 8'h4c, 1'b0, 2'b00);
		run(4'b0000, 1'b0, 7'h63, 8'h21, 8'h00, 1'b0, 2'b00);
		run(4'b1000, 1'b0, 7'h00, 8'h00, 8'h00, 1'b0, 2'b11);
		run(4'b1100, 1'b1, 7'h05, 8'h00, 8'hff, 1'b0, 2'b01);
		// Every code of the byte, bit and literal groups; branches only as the loop fixture
		for (i = 0; i < 64; i = i + 1) begin
			r = $urandom;
			run(i[3:0], r[0], r[7:1], r[15:8], r[23:16], r[24],
				(i[5:4] == 2'b10) ? 2'b00 : i[5:4]);
		end
		test_done;
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		errors = errors + 1;
		test_done;
	end
endmodule // testbench
